// ### rtl/uef_defines.svh
`ifndef UEF_DEFINES_SVH
`define UEF_DEFINES_SVH
// ----------------------------------------
// Setup packet codes
// ----------------------------------------
`define UEF_TYPE_VEND_IN     8'hC0
`define UEF_TYPE_VEND_OUT    8'h40
`define UEF_REQ_REG_READ     8'h00
`define UEF_REQ_REG_WRITE    8'h01
`define UEF_REQ_REG_WRITE1   8'h03
`define UEF_REQ_MEM_READ     8'h02
`define UEF_REQ_MEM_WRITE    8'h05
`define UEF_REQ_MEM_WRITE1   8'h07
`define UEF_REQ_CLR_FEATURE  8'h01
`define UEF_REQ_SET_FEATURE  8'h03
`define UEF_REQ_GET_DESC     8'h06
`define UEF_REQ_SET_DESC     8'h07
`define UEF_REQ_SYNCH_FRAME  8'h0C
`define UEF_RECIP_INTERFACE  5'h01
`define UEF_DESC_DEVICE      8'h01
`define UEF_DESC_CONFIG      8'h02
// ----------------------------------------
// Register space
// ----------------------------------------
`define UEF_REG_SPACE        64
`define UEF_OFF_NET_CTRL     6'h00
`define UEF_OFF_NET_STATUS   6'h01
`define UEF_OFF_RX_STATUS    6'h06
`define UEF_OFF_RX_OVERFLOW  6'h07
`define UEF_OFF_MEM_CTRL     6'h3F
`define UEF_BIT_WAKEUP       6
`define UEF_BIT_MEM_EN       0
// ----------------------------------------
// Packet sizes and descriptor defaults
// ----------------------------------------
`define UEF_PKT_LEN_FS       9'h040
`define UEF_PKT_LEN_HS       9'h100
`define UEF_INT_PKT_LEN      4'h8
`define UEF_DEV_DESC_LEN     5'h12
`define UEF_CFG_DESC_LEN     5'h09
`define UEF_CFG_TOTAL_LEN    16'h0027
`define UEF_MAX_POWER        8'h3C
`endif

// ### rtl/uef_pkg.sv
package uef_pkg;
  typedef enum logic [2:0] {
    UEF_RESP_NONE,
    UEF_RESP_ACK,
    UEF_RESP_NAK,
    UEF_RESP_DATA,
    UEF_RESP_STALL
  } uef_resp_t;

  typedef enum logic [2:0] {
    CT_IDLE,
    CT_REG_RD,
    CT_REG_WR,
    CT_MEM_RD,
    CT_MEM_WR,
    CT_DESC,
    CT_STALL
  } uef_ctrl_state_t;
endpackage

// ### rtl/uef_endpoints.sv
// The plain strobed port and the register offsets are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
`include "uef_defines.svh"
module uef_endpoints #(
  parameter logic [15:0] DEF_VENDOR_ID  = 16'h1111,  // Arbitrary value
  parameter logic [15:0] DEF_PRODUCT_ID = 16'h2222   // Arbitrary value
) (
  input  wire logic                 core_clk,
  input  wire logic                 rstn,
  input  wire logic [7:0]           reg_addr,
  input  wire logic [7:0]           reg_wdata,
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  output var  logic [7:0]           reg_rdata,
  input  wire logic                 high_speed,
  input  wire logic                 header_mode_strap,
  input  wire logic                 self_powered,
  input  wire logic                 eep_valid,
  input  wire logic [15:0]          eep_vendor_id,
  input  wire logic [15:0]          eep_product_id,
  input  wire logic [7:0]           eep_max_power,
  input  wire logic                 setup_valid,
  input  wire logic [63:0]          setup_data,
  input  wire logic                 ctrl_in_rd,
  output var  logic [7:0]           ctrl_in_byte,
  output var  logic                 ctrl_in_valid,
  input  wire logic                 ctrl_out_valid,
  input  wire logic [7:0]           ctrl_out_byte,
  output var  logic                 ctrl_stall,
  output var  logic [15:0]          mem_addr,
  output var  logic [7:0]           mem_wdata,
  output var  logic                 mem_wr,
  output var  logic                 mem_rd,
  input  wire logic [7:0]           mem_rdata,
  input  wire logic                 bin_token,
  output var  uef_pkg::uef_resp_t   bin_resp,
  output var  logic [8:0]           bin_len,
  input  wire logic                 bin_byte_rd,
  output var  logic [7:0]           bin_byte,
  input  wire logic                 rx_fifo_full,
  input  wire logic                 rx_frame_end,
  input  wire logic [8:0]           rx_fifo_level,
  input  wire logic                 rx_frame_start,
  input  wire logic [7:0]           rx_hdr_status,
  input  wire logic [7:0]           rx_hdr_csum,
  input  wire logic [15:0]          rx_hdr_count,
  input  wire logic [7:0]           rx_data,
  output var  logic                 rx_pop,
  input  wire logic                 bout_token,
  output var  uef_pkg::uef_resp_t   bout_resp,
  input  wire logic                 bout_byte_valid,
  input  wire logic [7:0]           bout_byte,
  input  wire logic                 bout_pkt_end,
  input  wire logic [8:0]           bout_pkt_len,
  input  wire logic                 tx_fifo_full,
  output var  logic                 tx_push,
  output var  logic [7:0]           tx_data,
  output var  logic                 tx_frame_end,
  output var  logic [15:0]          tx_frame_len,
  input  wire logic                 int_token,
  input  wire logic                 int_cond,
  output var  uef_pkg::uef_resp_t   int_resp,
  input  wire logic                 int_byte_rd,
  input  wire logic [2:0]           int_byte_idx,
  output var  logic [7:0]           int_byte,
  input  wire logic [7:0]           network_status_reg,
  input  wire logic [7:0]           receive_status_reg,
  input  wire logic [7:0]           receive_overflow_count,
  input  wire logic [7:0]           received_frame_count,
  input  wire logic [7:0]           transmitted_frame_count
);
  import uef_pkg::*;

  // ----------------------------------------
  // Register space and strap
  // ----------------------------------------
  logic [7:0]      regs [`UEF_REG_SPACE];
  logic            strap_meta;
  logic            strap_sync;
  logic [2:0]      strap_taken;
  logic            hdr4_mode;
  logic [8:0]      pkt_len;
  logic            mem_enable;
  logic [7:0]      cfg_attr;
  uef_ctrl_state_t ctrl_state;
  logic [15:0]     ptr;
  logic [7:0]      xfer_left;
  logic [4:0]      desc_idx;
  logic            desc_is_cfg;
  logic            mem_rd_d;
  logic            usb_reg_wr;
  logic [5:0]      usb_reg_off;
  logic [7:0]      usb_reg_data;

  assign pkt_len    = high_speed ? `UEF_PKT_LEN_HS : `UEF_PKT_LEN_FS;
  assign mem_enable = regs[`UEF_OFF_MEM_CTRL][`UEF_BIT_MEM_EN];
  // D7 set, D4 clear, D5 follows the wakeup enable bit
  assign cfg_attr   = {1'b1, self_powered,
                       regs[`UEF_OFF_NET_CTRL][`UEF_BIT_WAKEUP], 5'h00};

  // Strap goes through two flops, then is caught once after reset release
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      strap_meta  <= 1'b0;
      strap_sync  <= 1'b0;
      strap_taken <= 3'b000;
      hdr4_mode   <= 1'b0;
    end else begin
      strap_meta  <= header_mode_strap;
      strap_sync  <= strap_meta;
      strap_taken <= {strap_taken[1:0], 1'b1};
      // Third edge: the second flop holds the pin by now
      if (strap_taken == 3'b011) begin
        hdr4_mode <= strap_sync;
      end
    end
  end

  // USB writes win over a same-cycle software write to the same byte
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < `UEF_REG_SPACE; i++) begin
        regs[i] <= 8'h00;
      end
    end else begin
      if (reg_wr && reg_addr < 8'(`UEF_REG_SPACE)) begin
        regs[reg_addr[5:0]] <= reg_wdata;
      end
      if (usb_reg_wr) begin
        regs[usb_reg_off] <= usb_reg_data;
      end
    end
  end

  function automatic logic [7:0] reg_view(input logic [5:0] off);
    unique case (off)
      `UEF_OFF_NET_STATUS:  reg_view = network_status_reg;
      `UEF_OFF_RX_STATUS:   reg_view = receive_status_reg;
      `UEF_OFF_RX_OVERFLOW: reg_view = receive_overflow_count;
      default:              reg_view = regs[off];
    endcase
  endfunction

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= (reg_addr < 8'(`UEF_REG_SPACE)) ? reg_view(reg_addr[5:0]) : 8'h00;
    end
  end

  // ----------------------------------------
  // Descriptors
  // ----------------------------------------
  function automatic logic [7:0] desc_byte(input logic cfg, input logic [4:0] idx);
    logic [15:0] vid;
    logic [15:0] pid;
    vid = eep_valid ? eep_vendor_id : DEF_VENDOR_ID;
    pid = eep_valid ? eep_product_id : DEF_PRODUCT_ID;
    desc_byte = 8'h00;
    if (!cfg) begin
      unique case (idx)
        5'd0:  desc_byte = {3'b000, `UEF_DEV_DESC_LEN};
        5'd1:  desc_byte = `UEF_DESC_DEVICE;
        5'd2:  desc_byte = 8'h00;
        5'd3:  desc_byte = 8'h02;
        5'd7:  desc_byte = 8'h08;
        5'd8:  desc_byte = vid[7:0];
        5'd9:  desc_byte = vid[15:8];
        5'd10: desc_byte = pid[7:0];
        5'd11: desc_byte = pid[15:8];
        5'd12: desc_byte = 8'h01;
        5'd13: desc_byte = 8'h01;
        5'd14: desc_byte = 8'h01;
        5'd15: desc_byte = 8'h02;
        5'd16: desc_byte = 8'h03;
        5'd17: desc_byte = 8'h01;
        default: desc_byte = 8'h00;
      endcase
    end else begin
      unique case (idx)
        5'd0: desc_byte = {3'b000, `UEF_CFG_DESC_LEN};
        5'd1: desc_byte = `UEF_DESC_CONFIG;
        5'd2: desc_byte = 8'(`UEF_CFG_TOTAL_LEN);
        5'd3: desc_byte = 8'(`UEF_CFG_TOTAL_LEN >> 8);
        5'd4: desc_byte = 8'h01;
        5'd5: desc_byte = 8'h01;
        5'd7: desc_byte = cfg_attr;
        5'd8: desc_byte = eep_valid ? eep_max_power : `UEF_MAX_POWER;
        default: desc_byte = 8'h00;
      endcase
    end
  endfunction

  // ----------------------------------------
  // Control endpoint
  // ----------------------------------------
  logic [7:0] s_type;
  logic [7:0] s_req;
  logic [7:0] s_val_lo;
  logic [7:0] s_val_hi;
  logic [15:0] s_index;
  logic [7:0] s_len;
  assign s_type   = setup_data[7:0];
  assign s_req    = setup_data[15:8];
  assign s_val_lo = setup_data[23:16];
  assign s_val_hi = setup_data[31:24];
  assign s_index  = setup_data[47:32];
  assign s_len    = setup_data[55:48];

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_state    <= CT_IDLE;
      ptr           <= 16'h0000;
      xfer_left     <= 8'h00;
      desc_idx      <= 5'h00;
      desc_is_cfg   <= 1'b0;
      ctrl_in_byte  <= 8'h00;
      ctrl_in_valid <= 1'b0;
      ctrl_stall    <= 1'b0;
      mem_addr      <= 16'h0000;
      mem_wdata     <= 8'h00;
      mem_wr        <= 1'b0;
      mem_rd        <= 1'b0;
      mem_rd_d      <= 1'b0;
      usb_reg_wr    <= 1'b0;
      usb_reg_off   <= 6'h00;
      usb_reg_data  <= 8'h00;
    end else begin
      ctrl_in_valid <= 1'b0;
      mem_wr        <= 1'b0;
      mem_rd        <= 1'b0;
      usb_reg_wr    <= 1'b0;
      mem_rd_d      <= mem_rd;
      if (mem_rd_d) begin
        ctrl_in_byte  <= mem_rdata;
        ctrl_in_valid <= 1'b1;
      end
      if (setup_valid) begin
        ctrl_state <= CT_IDLE;
        ctrl_stall <= 1'b0;
        ptr        <= s_index;
        xfer_left  <= s_len;
        desc_idx   <= 5'h00;
        if ((s_req == `UEF_REQ_CLR_FEATURE || s_req == `UEF_REQ_SET_FEATURE)
            && s_type == {3'b000, `UEF_RECIP_INTERFACE}) begin
          ctrl_state <= CT_STALL;
          ctrl_stall <= 1'b1;
        end else if (s_type[6:5] == 2'b00
                     && (s_req == `UEF_REQ_SET_DESC || s_req == `UEF_REQ_SYNCH_FRAME)) begin
          ctrl_state <= CT_STALL;
          ctrl_stall <= 1'b1;
        end else if (s_type == 8'h80 && s_req == `UEF_REQ_GET_DESC
                     && (s_val_hi == `UEF_DESC_DEVICE || s_val_hi == `UEF_DESC_CONFIG)) begin
          ctrl_state  <= CT_DESC;
          desc_is_cfg <= (s_val_hi == `UEF_DESC_CONFIG);
        end else if (s_type == `UEF_TYPE_VEND_IN && s_req == `UEF_REQ_REG_READ) begin
          ctrl_state <= CT_REG_RD;
        end else if (s_type == `UEF_TYPE_VEND_OUT && s_req == `UEF_REQ_REG_WRITE) begin
          ctrl_state <= CT_REG_WR;
        end else if (s_type == `UEF_TYPE_VEND_OUT && s_req == `UEF_REQ_REG_WRITE1) begin
          // reg_single_write_req: data rides in wValue, no data stage
          if (s_index[7:0] < 8'(`UEF_REG_SPACE)) begin
            usb_reg_wr   <= 1'b1;
            usb_reg_off  <= s_index[5:0];
            usb_reg_data <= s_val_lo;
          end
        end else if ((s_type == `UEF_TYPE_VEND_IN && s_req == `UEF_REQ_MEM_READ)
                     || (s_type == `UEF_TYPE_VEND_OUT
                         && (s_req == `UEF_REQ_MEM_WRITE
                             || s_req == `UEF_REQ_MEM_WRITE1))) begin
          if (!mem_enable) begin
            ctrl_state <= CT_STALL;
            ctrl_stall <= 1'b1;
          end else if (s_req == `UEF_REQ_MEM_READ) begin
            ctrl_state <= CT_MEM_RD;
          end else if (s_req == `UEF_REQ_MEM_WRITE) begin
            ctrl_state <= CT_MEM_WR;
          end else begin
            mem_wr    <= 1'b1;
            mem_addr  <= s_index;
            mem_wdata <= s_val_lo;
          end
        end else if (s_type[6:5] == 2'b10) begin
          ctrl_state <= CT_STALL;
          ctrl_stall <= 1'b1;
        end
      end else if (ctrl_in_rd) begin
        unique case (ctrl_state)
          CT_REG_RD: begin
            ctrl_in_valid <= 1'b1;
            ctrl_in_byte  <= (xfer_left != 8'h00 && ptr < 16'(`UEF_REG_SPACE))
                             ? reg_view(ptr[5:0]) : 8'h00;
            ptr           <= ptr + 16'h0001;
            if (xfer_left != 8'h00) xfer_left <= xfer_left - 8'h01;
          end
          CT_MEM_RD: begin
            if (xfer_left != 8'h00) begin
              mem_rd    <= 1'b1;
              mem_addr  <= ptr;
              ptr       <= ptr + 16'h0001;
              xfer_left <= xfer_left - 8'h01;
            end else begin
              ctrl_in_valid <= 1'b1;
              ctrl_in_byte  <= 8'h00;
            end
          end
          CT_DESC: begin
            ctrl_in_valid <= 1'b1;
            ctrl_in_byte  <= desc_byte(desc_is_cfg, desc_idx);
            if (desc_idx != 5'h1F) desc_idx <= desc_idx + 5'h01;
          end
          default: begin
            ctrl_in_valid <= 1'b1;
            ctrl_in_byte  <= 8'h00;
          end
        endcase
      end else if (ctrl_out_valid && xfer_left != 8'h00) begin
        if (ctrl_state == CT_REG_WR) begin
          if (ptr < 16'(`UEF_REG_SPACE)) begin
            usb_reg_wr   <= 1'b1;
            usb_reg_off  <= ptr[5:0];
            usb_reg_data <= ctrl_out_byte;
          end
          ptr       <= ptr + 16'h0001;
          xfer_left <= xfer_left - 8'h01;
        end else if (ctrl_state == CT_MEM_WR) begin
          mem_wr    <= 1'b1;
          mem_addr  <= ptr;
          mem_wdata <= ctrl_out_byte;
          ptr       <= ptr + 16'h0001;
          xfer_left <= xfer_left - 8'h01;
        end
      end
    end
  end

  // ----------------------------------------
  // Bulk receive endpoint
  // ----------------------------------------
  logic [7:0]  hdr_status;
  logic [7:0]  hdr_csum;
  logic [15:0] hdr_count;
  logic [2:0]  hdr_left;
  logic [2:0]  hdr_total;
  logic [7:0]  hdr_byte;
  logic [2:0]  hdr_pos;

  assign hdr_total = hdr4_mode ? 3'd4 : 3'd3;
  assign hdr_pos   = hdr_total - hdr_left;

  always_comb begin
    hdr_byte = 8'h00;
    if (hdr4_mode) begin
      unique case (hdr_pos)
        3'd0:    hdr_byte = hdr_status;
        3'd1:    hdr_byte = {hdr_csum[7:2], 2'b00};
        3'd2:    hdr_byte = hdr_count[7:0];
        default: hdr_byte = hdr_count[15:8];
      endcase
    end else begin
      unique case (hdr_pos)
        3'd0:    hdr_byte = hdr_status;
        3'd1:    hdr_byte = hdr_count[7:0];
        default: hdr_byte = hdr_count[15:8];
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      hdr_status <= 8'h00;
      hdr_csum   <= 8'h00;
      hdr_count  <= 16'h0000;
      hdr_left   <= 3'd0;
      bin_resp   <= UEF_RESP_NONE;
      bin_len    <= 9'h000;
      bin_byte   <= 8'h00;
      rx_pop     <= 1'b0;
    end else begin
      bin_resp <= UEF_RESP_NONE;
      rx_pop   <= 1'b0;
      if (bin_token) begin
        if (rx_fifo_full) begin
          bin_resp <= UEF_RESP_DATA;
          bin_len  <= pkt_len;
        end else if (rx_frame_end) begin
          bin_resp <= UEF_RESP_DATA;
          bin_len  <= (rx_fifo_level + 9'(hdr_left) > pkt_len)
                      ? pkt_len : rx_fifo_level + 9'(hdr_left);
        end else begin
          bin_resp <= UEF_RESP_NAK;
        end
      end
      if (rx_frame_start) begin
        hdr_status <= rx_hdr_status;
        hdr_csum   <= rx_hdr_csum;
        hdr_count  <= rx_hdr_count;
        hdr_left   <= hdr_total;
      end else if (bin_byte_rd) begin
        // Header bytes go out ahead of any frame data
        if (hdr_left != 3'd0) begin
          bin_byte <= hdr_byte;
          hdr_left <= hdr_left - 3'd1;
        end else begin
          bin_byte <= rx_data;
          rx_pop   <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------
  // Bulk transmit endpoint
  // ----------------------------------------
  logic       out_accept;
  logic [1:0] len_bytes;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      out_accept   <= 1'b0;
      len_bytes    <= 2'd0;
      bout_resp    <= UEF_RESP_NONE;
      tx_push      <= 1'b0;
      tx_data      <= 8'h00;
      tx_frame_end <= 1'b0;
      tx_frame_len <= 16'h0000;
    end else begin
      bout_resp    <= UEF_RESP_NONE;
      tx_push      <= 1'b0;
      tx_frame_end <= 1'b0;
      if (bout_token) begin
        out_accept <= !tx_fifo_full;
        bout_resp  <= tx_fifo_full ? UEF_RESP_NAK : UEF_RESP_ACK;
      end
      // A refused packet is dropped byte by byte
      if (bout_byte_valid && out_accept) begin
        tx_push <= 1'b1;
        tx_data <= bout_byte;
        if (len_bytes == 2'd0) begin
          tx_frame_len[7:0] <= bout_byte;
          len_bytes         <= 2'd1;
        end else if (len_bytes == 2'd1) begin
          tx_frame_len[15:8] <= bout_byte;
          len_bytes          <= 2'd2;
        end
      end
      if (bout_pkt_end && out_accept && bout_pkt_len < pkt_len) begin
        tx_frame_end <= 1'b1;
        len_bytes    <= 2'd0;
      end
    end
  end

  // ----------------------------------------
  // Status interrupt endpoint
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      int_resp <= UEF_RESP_NONE;
      int_byte <= 8'h00;
    end else begin
      int_resp <= UEF_RESP_NONE;
      if (int_token) begin
        int_resp <= int_cond ? UEF_RESP_DATA : UEF_RESP_NAK;
      end
      if (int_byte_rd) begin
        unique case (int_byte_idx)
          3'd0:    int_byte <= network_status_reg;
          3'd3:    int_byte <= receive_status_reg;
          3'd4:    int_byte <= receive_overflow_count;
          3'd5:    int_byte <= received_frame_count;
          3'd6:    int_byte <= transmitted_frame_count;
          default: int_byte <= 8'h00;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// ### verification/uef_endpoints_assertions.sv
`timescale 1ns/100ps
`default_nettype none
// ----
// Endpoint handshake checks
// ----
module uef_chk (
  input wire logic               core_clk, rstn, high_speed, bin_token, rx_fifo_full,
  input wire logic               rx_frame_end, bout_token, tx_fifo_full, int_token,
  input wire logic               int_cond, setup_valid, ctrl_stall,
  input wire logic [8:0]         bin_len,
  input wire uef_pkg::uef_resp_t bin_resp, bout_resp, int_resp
);
  import uef_pkg::*;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  // Length judged from the speed seen with the token, not after it
  a_bin_full_pkt: assert property (bin_token && rx_fifo_full |=>
    bin_resp == UEF_RESP_DATA && bin_len == ($past(high_speed) ? 9'h100 : 9'h040))
    else $error("full fifo not sent whole");
  a_bin_open_nak: assert property (bin_token && !rx_fifo_full && !rx_frame_end |=>
    bin_resp == UEF_RESP_NAK) else $error("open frame not refused");
  a_bin_short_pkt: assert property (bin_token && !rx_fifo_full && rx_frame_end |=>
    bin_resp == UEF_RESP_DATA && bin_len <= ($past(high_speed) ? 9'h100 : 9'h040))
    else $error("ended frame not flushed");
  a_out_ack: assert property (bout_token && !tx_fifo_full |=> bout_resp == UEF_RESP_ACK)
    else $error("free fifo not acked");
  a_out_nak: assert property (bout_token && tx_fifo_full |=> bout_resp == UEF_RESP_NAK)
    else $error("full fifo not refused");
  a_int_nak: assert property (int_token && !int_cond |=> int_resp == UEF_RESP_NAK)
    else $error("idle status not refused");
  a_int_data: assert property (int_token && int_cond |=> int_resp == UEF_RESP_DATA)
    else $error("status not sent");
  a_stall_holds: assert property (ctrl_stall && !setup_valid |=> ctrl_stall)
    else $error("stall dropped early");
  cover property (bin_token && rx_fifo_full);
  cover property (bout_token && tx_fifo_full);
  cover property (int_token && int_cond);
endmodule
bind uef_endpoints uef_chk u_chk (.*);
`default_nettype wire

// ### verification/uef_host_model.sv
`timescale 1ns/100ps
`default_nettype none
// ----
// Host side of the bulk transmit endpoint
// ----
module uef_host (
  input  wire logic       core_clk,
  output var  logic       bout_token,
  output var  logic       bout_byte_valid,
  output var  logic       bout_pkt_end,
  output var  logic [7:0] bout_byte,
  output var  logic [8:0] bout_pkt_len
);
  initial {bout_token, bout_byte_valid, bout_pkt_end, bout_byte, bout_pkt_len} = '0;
  // One frame in one short packet, so n stays below 62
  task send(input logic [15:0] n, input logic [7:0] d0);
    @(posedge core_clk) bout_token <= 1;
    @(posedge core_clk) bout_token <= 0;
    for (int i = 0; i < n + 2; i++) begin
      @(posedge core_clk) bout_byte_valid <= 1;
      bout_byte <= i == 0 ? n[7:0] : i == 1 ? n[15:8] : d0 + 8'(i - 2);
    end
    @(posedge core_clk) bout_byte_valid <= 0;
    bout_byte <= ~bout_byte;
    bout_pkt_end <= 1;
    bout_pkt_len <= 9'(n + 2);
    @(posedge core_clk) bout_pkt_end <= 0;
  endtask
endmodule
`default_nettype wire

// ### verification/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import uef_pkg::*;
  // ----
  // Stimulus and expected bytes
  // ----
  logic core_clk = 0, rstn = 0, reg_wr = 0, reg_rd = 0, high_speed = 0, self_powered = 0;
  logic setup_valid = 0, ctrl_in_rd = 0, ctrl_out_valid = 0, bin_token = 0, bin_byte_rd = 0;
  logic rx_fifo_full = 0, rx_frame_end = 0, rx_frame_start = 0, tx_fifo_full = 0;
  logic int_token = 0, int_cond = 0, int_byte_rd = 0, ctrl_in_valid, ctrl_stall, mem_wr;
  logic mem_rd, rx_pop, tx_push, tx_frame_end, bout_token, bout_byte_valid, bout_pkt_end;
  logic [7:0] reg_addr = 0, reg_wdata = 0, ctrl_out_byte = 0, mem_rdata = 0, rx_data = 0;
  logic header_mode_strap = 0;
  logic [7:0] rx_hdr_status = 0, rx_hdr_csum = 8'hFF, network_status_reg = 8'h5A;
  logic [7:0] receive_status_reg = 8'h61, receive_overflow_count = 8'h07;
  logic [7:0] received_frame_count = 8'h0B, transmitted_frame_count = 8'h0C;
  logic [7:0] reg_rdata, ctrl_in_byte, mem_wdata, bin_byte, tx_data, int_byte, bout_byte, d;
  logic [8:0] rx_fifo_level = 0, bin_len, bout_pkt_len;
  logic [15:0] rx_hdr_count = 0, mem_addr, tx_frame_len;
  logic [63:0] setup_data = 0;
  logic [2:0] int_byte_idx = 0;
  uef_resp_t bin_resp, bout_resp, int_resp;
  logic [7:0] pushed[$];
  int miscompares = 0, n_compared = 0, n_end = 0;
  // Vendor and product bytes are the design's arbitrary defaults
  localparam logic [143:0] DEV = 144'h1201_0002_0000_0008_1111_2222_0101_0102_0301;
  localparam logic [71:0] CFG = 72'h09_0227_0001_0100_A03C;
  localparam logic [63:0] STS = 64'h5A00_0061_070B_0C00;
  uef_endpoints uut (.*, .eep_valid(1'b0),
    .eep_vendor_id(16'h0000), .eep_product_id(16'h0000), .eep_max_power(8'h00));
  uef_host host (.*);
  always #12.5 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    if (tx_push) pushed.push_back(tx_data);
    if (tx_frame_end) n_end++;
  end
  task check(input logic [15:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: %h not %h", $time, seen, exp);
    end
  endtask
  task stop_test;
    $display("%0d compared, %0d miscompares", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task wr(input logic [7:0] a, v);
    @(posedge core_clk) reg_wr <= 1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge core_clk) reg_wr <= 0;
  endtask
  task rd(input logic [7:0] a);
    @(posedge core_clk) reg_rd <= 1;
    reg_addr <= a;
    @(posedge core_clk) reg_rd <= 0;
    @(negedge core_clk) d = reg_rdata;
  endtask
  task setup(input logic [63:0] s);
    @(posedge core_clk) setup_valid <= 1;
    setup_data <= s;
    @(posedge core_clk) setup_valid <= 0;
    @(negedge core_clk);
  endtask
  task cin(input logic [7:0] e);
    @(posedge core_clk) ctrl_in_rd <= 1;
    @(posedge core_clk) ctrl_in_rd <= 0;
    @(negedge core_clk) check(ctrl_in_valid, 1);
    check(ctrl_in_byte, e);
  endtask
  task btok(input logic f, e, h, input uef_resp_t r, input logic [8:0] n);
    @(posedge core_clk) bin_token <= 1;
    rx_fifo_full <= f;
    rx_frame_end <= e;
    high_speed <= h;
    @(posedge core_clk) bin_token <= 0;
    @(negedge core_clk) check(bin_resp, r);
    if (r == UEF_RESP_DATA) check(bin_len, n);
  endtask
  task t_ctrl;
    logic [15:0] bad [7] = '{16'h0101, 16'h0301, 16'h0700, 16'h0C82, 16'h02C0, 16'h0540, 16'h0740};
    wr(8'h00, 8'h40);
    rd(8'h01);
    check(d, 8'h5A);
    rd(8'h40);
    check(d, 8'h00);
    foreach (bad[i]) begin
      setup({48'h0, bad[i]});
      check(ctrl_stall, 1);
    end
    setup({16'h0000, 16'h003E, 16'h0077, 16'h0340});
    check(ctrl_stall, 0);
    rd(8'h3E);
    check(d, 8'h77);
    setup({16'h0001, 16'h003E, 16'h0000, 16'h00C0});
    cin(8'h77);
    cin(8'h00);
    setup(64'h0001_0010_0000_0140);
    @(posedge core_clk) ctrl_out_valid <= 1;
    ctrl_out_byte <= 8'h3C;
    @(posedge core_clk) ctrl_out_valid <= 0;
    rd(8'h10);
    check(d, 8'h3C);
    wr(8'h3F, 8'h01);
    setup({16'h0000, 16'h1234, 16'h005C, 16'h0740});
    for (int i = 0; i < 8 && mem_wr !== 1; i++) @(negedge core_clk);
    check(mem_wr, 1);
    check(mem_addr, 16'h1234);
    check(mem_wdata, 8'h5C);
    setup({16'h0012, 16'h0000, 16'h0100, 16'h0680});
    for (int i = 0; i < 18; i++) cin(DEV[143 - 8 * i -: 8]);
    setup({16'h0009, 16'h0000, 16'h0200, 16'h0680});
    for (int i = 0; i < 9; i++) cin(CFG[71 - 8 * i -: 8]);
    $display("control test finished");
  endtask
  task hdr(input int n, input logic [39:0] e);
    @(posedge core_clk) rx_frame_start <= 1;
    @(posedge core_clk) rx_frame_start <= 0;
    for (int i = 0; i < n; i++) begin
      @(posedge core_clk) bin_byte_rd <= 1;
      @(posedge core_clk) bin_byte_rd <= 0;
      @(negedge core_clk) check(bin_byte, e[39 - 8 * i -: 8]);
      check(rx_pop, i == n - 1);
    end
  endtask
  task t_bulk;
    @(posedge core_clk) rx_hdr_status <= 8'h41;
    rx_hdr_count <= 16'h0203;
    rx_data <= 8'h99;
    rx_fifo_level <= 9'h005;
    hdr(4, 40'h4103_0299_00);
    btok(1, 0, 0, UEF_RESP_DATA, 9'h040);
    btok(0, 0, 0, UEF_RESP_NAK, 9'h000);
    btok(0, 1, 0, UEF_RESP_DATA, 9'h005);
    btok(1, 1, 1, UEF_RESP_DATA, 9'h100);
    host.send(16'h0004, 8'hB0);
    repeat (3) @(negedge core_clk);
    check(n_end, 1);
    check(tx_frame_len, 16'h0004);
    check(pushed[$], 8'hB3);
    @(posedge core_clk) tx_fifo_full <= 1;
    pushed.delete();
    host.send(16'h0002, 8'hC0);
    repeat (3) @(negedge core_clk);
    check(pushed.size(), 0);
    check(n_end, 1);
    @(posedge core_clk) rstn <= 0;
    header_mode_strap <= 1;
    repeat (2) @(posedge core_clk);
    rstn <= 1;
    repeat (4) @(posedge core_clk);
    hdr(5, 40'h41FC_0302_99);
    $display("bulk test finished");
  endtask
  task t_int;
    for (int c = 0; c < 2; c++) begin
      @(posedge core_clk) int_token <= 1;
      int_cond <= c[0];
      @(posedge core_clk) int_token <= 0;
      @(negedge core_clk) check(int_resp, c ? UEF_RESP_DATA : UEF_RESP_NAK);
    end
    for (int i = 0; i < 8; i++) begin
      @(posedge core_clk) int_byte_rd <= 1;
      int_byte_idx <= 3'(i);
      @(posedge core_clk) int_byte_rd <= 0;
      @(negedge core_clk) check(int_byte, STS[63 - 8 * i -: 8]);
    end
    $display("interrupt test finished");
  endtask
  initial begin
    repeat (5) @(posedge core_clk);
    rstn <= 1;
    repeat (4) @(posedge core_clk);
    t_ctrl;
    t_bulk;
    t_int;
    stop_test;
  end
  initial begin
    #100us;
    miscompares++;
    stop_test;
  end
endmodule
`default_nettype wire
